// >>> hw/sys_ctrl_status.sv
// System control word, event flags, bus clear, arbiter gating and core-disable pin muxing.
// Assumes request strobes from same-clock logic; pins from outside are synchronised here.
//
// How it works
// - Control word answers only at address 0F4 with function code 5.
// - Top bits are sticky event flags, readable at any time.
// - Writing one clears a flag, zero leaves it; several at once.
// - System reset clears every event flag.
// - Unmasked core interrupt sets the interrupt flag regardless of bus-clear mask.
// - Mask bit set, core enabled: pending interrupt drives external and internal bus clear.
// - Interrupt bus clear holds until software clears the interrupt flag.
// - Watchdog expiry sets timeout flag and always raises bus error.
// - Write to read-only region sets write-guard flag regardless of enable.
// - Write-guard enable at bit 17 raises bus error on the violating cycle.
// - Two or more chip selects at once set the decode-clash flag.
// - Decode-clash enable at bit 16 makes a clash raise bus error.
// - Clashing chip selects resolve by fixed priority, one line only.
// - Clash during configuration register access sets nothing and errors nothing.
// - Split bit zero: strobe held through locked cycle; lock still withholds grants.
// - Split bit one: strobe drops after read part, returns for write part.
// - Core lock signal withholds all bus grants until its cycle ends, except in core-disable mode.
// - Extra-wait bit adds one wait state for external master accesses that use chip-select ack or a peripheral.
// - Core-disable pin caught at system reset keeps the core disabled.
// - Core-disable: DMA request out, grant in, bus clear input to block DMA.
// - Core-disable: interrupt levels on shared pins, no vectors supplied.
// - External master can take the bus through request and arbiter grant.
`timescale 1ns/100ps

module sys_ctrl_status
    import sys_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire sys_ctrl_pkg::reg_req_t reg_req,
    output sys_ctrl_pkg::reg_rsp_t reg_rsp,
    input wire logic core_irq_pending,
    input wire logic wdog_expired,
    input wire sys_ctrl_pkg::cs_evt_t cs_evt,
    output logic [3:0] chip_select_q,
    output logic bus_error_line_q,
    input wire logic core_as_req,
    input wire logic locked_cycle_sig,
    input wire logic rmw_read_done,
    input wire logic rmw_write_start,
    output logic address_strobe_line_q,
    input wire sys_ctrl_pkg::arb_in_t arb_in,
    output sys_ctrl_pkg::arb_out_t arb_out,
    input wire logic bus_request_line,
    input wire logic bus_grant_line,
    input wire logic bus_clear_in,
    input wire logic ext_master_cycle,
    input wire logic cs_ack_used,
    input wire logic periph_access,
    output logic extra_wait_q,
    input wire logic core_disable_in,
    output logic core_enable_q,
    input wire logic [2:0] irq_level_line,
    output logic [2:0] irq_level_out_q,
    output logic [2:0] irq_level_out_oe_q,
    output logic vector_enable_q
);
    import sys_ctrl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] ext_req_s;
        logic [1:0] grant_s;
        logic [1:0] bus_clear_line_s;
        logic [1:0] cdis_s;
        logic core_dis;
        logic core_en;
        logic irq_flag;
        logic timeout_flag;
        logic wg_flag;
        logic dc_flag;
        logic wg_err_en;
        logic dc_err_en;
        logic locked_split;
        logic ext_extra_wait;
        logic irq_bus_clear_line_en;
        logic rmw_gap;
        logic [3:0] cs_sel;
        logic bus_error_line;
        logic as_out;
        logic xwait;
        logic [2:0] irq_out;
        logic [2:0] irq_oe;
        logic vec_en;
        reg_rsp_t rsp;
        arb_out_t arb;
    } state_t;

    state_t st_q;
    state_t st_d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Fixed priority: lowest index wins
    function automatic logic [3:0] first_one(input logic [3:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 3; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'h0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic many(input logic [3:0] v);
        return (v & (v - 4'h1)) != 4'h0;
    endfunction

    // ------------------------------------------------------------
    // Next-state scratch
    // ------------------------------------------------------------
    logic hit;
    logic wr_hit;
    logic clash;
    logic wg_evt;
    logic [31:0] word;
    logic lock_hold;
    logic any_req;
    logic grant_src;
    logic irq_bus_clear_line;

    always_comb begin
        st_d = st_q;

        // ------------------------------------------------------------
        // Pin synchronisers
        // ------------------------------------------------------------
        // Only the second stage feeds logic
        st_d.ext_req_s = {st_q.ext_req_s[0], bus_request_line};
        st_d.grant_s = {st_q.grant_s[0], bus_grant_line};
        st_d.bus_clear_line_s = {st_q.bus_clear_line_s[0], bus_clear_in};
        st_d.cdis_s = {st_q.cdis_s[0], core_disable_in};

        // ------------------------------------------------------------
        // Register access
        // ------------------------------------------------------------
        hit = reg_req.sel && reg_req.addr == SCW_ADDR && reg_req.fc == FC_SUPV_DATA;
        wr_hit = hit && reg_req.wr;

        word = 32'h00000000;
        word[BIT_IRQ_PENDING] = st_q.irq_flag;
        word[BIT_BUS_TIMEOUT] = st_q.timeout_flag;
        word[BIT_WRITE_GUARD] = st_q.wg_flag;
        word[BIT_DECODE_CLASH] = st_q.dc_flag;
        word[BIT_EXT_EXTRA_WAIT] = st_q.ext_extra_wait;
        word[BIT_LOCKED_SPLIT] = st_q.locked_split;
        word[BIT_WG_ERR_EN] = st_q.wg_err_en;
        word[BIT_DC_ERR_EN] = st_q.dc_err_en;
        word[BIT_IRQ_BUS_CLEAR_LINE_EN] = st_q.irq_bus_clear_line_en;
        st_d.rsp.ack = hit;
        st_d.rsp.rdata = (hit && !reg_req.wr) ? word : 32'h00000000;

        // ------------------------------------------------------------
        // Event flags: write one clears, event set wins
        // ------------------------------------------------------------
        if (wr_hit) begin
            if (reg_req.wdata[BIT_IRQ_PENDING]) begin
                st_d.irq_flag = 1'b0;
            end
            if (reg_req.wdata[BIT_BUS_TIMEOUT]) begin
                st_d.timeout_flag = 1'b0;
            end
            if (reg_req.wdata[BIT_WRITE_GUARD]) begin
                st_d.wg_flag = 1'b0;
            end
            if (reg_req.wdata[BIT_DECODE_CLASH]) begin
                st_d.dc_flag = 1'b0;
            end
            st_d.ext_extra_wait = reg_req.wdata[BIT_EXT_EXTRA_WAIT];
            st_d.locked_split = reg_req.wdata[BIT_LOCKED_SPLIT];
            st_d.wg_err_en = reg_req.wdata[BIT_WG_ERR_EN];
            st_d.dc_err_en = reg_req.wdata[BIT_DC_ERR_EN];
            st_d.irq_bus_clear_line_en = reg_req.wdata[BIT_IRQ_BUS_CLEAR_LINE_EN];
        end

        clash = cs_evt.cycle_valid && many(cs_evt.match) && !cs_evt.cfg_access;
        wg_evt = cs_evt.cycle_valid && cs_evt.ro_write;

        if (core_irq_pending) begin
            st_d.irq_flag = 1'b1;
        end
        if (wdog_expired) begin
            st_d.timeout_flag = 1'b1;
        end
        if (wg_evt) begin
            st_d.wg_flag = 1'b1;
        end
        if (clash) begin
            st_d.dc_flag = 1'b1;
        end

        // ------------------------------------------------------------
        // Chip select and bus error
        // ------------------------------------------------------------
        // No select on a guarded write or a configuration access
        st_d.cs_sel = (cs_evt.cycle_valid && !cs_evt.cfg_access && !wg_evt)
            ? first_one(cs_evt.match) : 4'h0;
        st_d.bus_error_line = wdog_expired
            || (wg_evt && st_q.wg_err_en)
            || (clash && st_q.dc_err_en);

        // ------------------------------------------------------------
        // Locked read-modify-write strobe
        // ------------------------------------------------------------
        // Gap opens only while the lock is held
        if (!locked_cycle_sig || rmw_write_start) begin
            st_d.rmw_gap = 1'b0;
        end else if (rmw_read_done && st_q.locked_split) begin
            st_d.rmw_gap = 1'b1;
        end
        st_d.as_out = core_as_req && !st_d.rmw_gap;

        // ------------------------------------------------------------
        // Arbiter gating and bus clear
        // ------------------------------------------------------------
        // While the core is enabled, lock withholds every grant, external and DMA alike
        lock_hold = locked_cycle_sig && !st_q.core_dis;
        any_req = st_q.ext_req_s[1] || arb_in.serial_dma_req || arb_in.block_dma_req;
        grant_src = st_q.core_dis ? st_q.grant_s[1] : arb_in.core_grant;
        st_d.arb.core_req = any_req && !st_q.core_dis;
        st_d.arb.grant_ext = grant_src && !lock_hold && !st_q.core_dis
            && st_q.ext_req_s[1];
        st_d.arb.grant_serial_dma = grant_src && !lock_hold && arb_in.serial_dma_req
            && (st_q.core_dis || !st_q.ext_req_s[1]);
        st_d.arb.grant_block_dma = grant_src && !lock_hold && arb_in.block_dma_req
            && !arb_in.serial_dma_req && (st_q.core_dis || !st_q.ext_req_s[1]);
        st_d.arb.dma_bus_request = st_q.core_dis
            && (arb_in.serial_dma_req || arb_in.block_dma_req);

        // Follows the flag, so it holds until software clears it
        irq_bus_clear_line = st_q.irq_bus_clear_line_en && st_q.irq_flag && !st_q.core_dis;
        st_d.arb.bus_clear = arb_in.serial_dma_req || irq_bus_clear_line;
        st_d.arb.internal_bus_clear = (st_q.ext_req_s[1] && !st_q.core_dis) || irq_bus_clear_line
            || (st_q.core_dis && st_q.bus_clear_line_s[1]);

        // ------------------------------------------------------------
        // External master wait state
        // ------------------------------------------------------------
        st_d.xwait = st_q.ext_extra_wait && ext_master_cycle
            && (cs_ack_used || periph_access);

        // ------------------------------------------------------------
        // Core-disable pin functions
        // ------------------------------------------------------------
        st_d.irq_out = st_q.core_dis ? irq_level_line : 3'h0;
        st_d.irq_oe = {3{st_q.core_dis}};
        st_d.vec_en = !st_q.core_dis;
        st_d.core_en = !st_q.core_dis;

        // ------------------------------------------------------------
        // System reset
        // ------------------------------------------------------------
        if (!reset_n) begin
            st_d = '0;
            st_d.irq_flag = FLAGS_RST[3];
            st_d.timeout_flag = FLAGS_RST[2];
            st_d.wg_flag = FLAGS_RST[1];
            st_d.dc_flag = FLAGS_RST[0];
            st_d.ext_req_s = SYNC_RST;
            st_d.grant_s = SYNC_RST;
            st_d.bus_clear_line_s = SYNC_RST;
            // Disable pin taken on every reset edge; keep it steady
            st_d.cdis_s = {st_q.cdis_s[0], core_disable_in};
            st_d.core_dis = st_q.cdis_s[1];
            st_d.core_en = !st_q.cdis_s[1];
            st_d.ext_extra_wait = CTRL_RST;
            st_d.locked_split = CTRL_RST;
            st_d.wg_err_en = CTRL_RST;
            st_d.dc_err_en = CTRL_RST;
            st_d.irq_bus_clear_line_en = CTRL_RST;
            st_d.vec_en = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_q <= st_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rsp = st_q.rsp;
    assign chip_select_q = st_q.cs_sel;
    assign bus_error_line_q = st_q.bus_error_line;
    assign address_strobe_line_q = st_q.as_out;
    assign arb_out = st_q.arb;
    assign extra_wait_q = st_q.xwait;
    assign core_enable_q = st_q.core_en;
    assign irq_level_out_q = st_q.irq_out;
    assign irq_level_out_oe_q = st_q.irq_oe;
    assign vector_enable_q = st_q.vec_en;

endmodule

// >>> hw/sys_ctrl_pkg.sv
// Constants and types for the system control and status logic.
// Assumes one 50 MHz system clock and a synchronous active-low reset.
package sys_ctrl_pkg;

    // ------------------------------------------------------------
    // Register location
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam logic [ADDR_W-1:0] SCW_ADDR = 24'h0000F4;
    localparam logic [2:0] FC_SUPV_DATA = 3'h5;

    // ------------------------------------------------------------
    // Field positions of the system control word
    // ------------------------------------------------------------
    localparam int BIT_IRQ_PENDING = 31;
    localparam int BIT_BUS_TIMEOUT = 30;
    localparam int BIT_WRITE_GUARD = 29;
    localparam int BIT_DECODE_CLASH = 28;
    localparam int BIT_EXT_EXTRA_WAIT = 19;
    localparam int BIT_LOCKED_SPLIT = 18;
    localparam int BIT_WG_ERR_EN = 17;
    localparam int BIT_DC_ERR_EN = 16;
    localparam int BIT_IRQ_BUS_CLEAR_LINE_EN = 15;
    localparam logic [31:0] FLAG_MASK = 32'hF0000000;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [1:0] SYNC_RST = 2'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic sel;
        logic wr;
        logic [2:0] fc;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } reg_rsp_t;

    typedef struct packed {
        logic cycle_valid;
        logic cfg_access;
        logic [3:0] match;
        logic ro_write;
    } cs_evt_t;

    typedef struct packed {
        logic serial_dma_req;
        logic block_dma_req;
        logic core_grant;
    } arb_in_t;

    typedef struct packed {
        logic core_req;
        logic grant_ext;
        logic grant_serial_dma;
        logic grant_block_dma;
        logic dma_bus_request;
        logic bus_clear;
        logic internal_bus_clear;
    } arb_out_t;

endpackage

// >>> dv/sys_ctrl_props.sv
// Checker for the system control word, bus errors, chip selects and arbiter.
// Bound into sys_ctrl_status; sees only that module's ports.
`timescale 1ns/100ps
module sys_ctrl_props
    import sys_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire sys_ctrl_pkg::reg_req_t reg_req,
    input wire sys_ctrl_pkg::reg_rsp_t reg_rsp,
    input wire logic wdog_expired,
    input wire sys_ctrl_pkg::cs_evt_t cs_evt,
    input wire logic [3:0] chip_select_q,
    input wire logic bus_error_line_q,
    input wire logic locked_cycle_sig,
    input wire logic rmw_read_done,
    input wire logic address_strobe_line_q,
    input wire sys_ctrl_pkg::arb_out_t arb_out,
    input wire logic core_enable_q
);
    logic hit;
    logic [4:0] ctl_q;
    logic [3:0] m;
    assign hit = reg_req.sel && reg_req.addr == SCW_ADDR && reg_req.fc == FC_SUPV_DATA;
    assign m = cs_evt.match;
    // Shadow of control bits 19..15
    always_ff @(posedge sys_clk) begin
        ctl_q <= !reset_n ? 5'h00 : (hit && reg_req.wr) ? reg_req.wdata[19:15] : ctl_q;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    ack_hit_a: assert property (hit |=> reg_rsp.ack)
        else $error("control word access not acknowledged");
    ack_miss_a: assert property (!hit |=> !reg_rsp.ack)
        else $error("acknowledge without a matching access");
    timeout_err_a: assert property (wdog_expired |=> bus_error_line_q)
        else $error("watchdog expiry without bus error");
    guard_err_a: assert property (cs_evt.cycle_valid && cs_evt.ro_write && ctl_q[2]
        |=> bus_error_line_q) else $error("write guard without bus error");
    clash_err_a: assert property (cs_evt.cycle_valid && !cs_evt.cfg_access &&
        !$onehot0(m) && ctl_q[1] |=> bus_error_line_q) else $error("clash without bus error");
    cfg_quiet_a: assert property (!wdog_expired &&
        !(cs_evt.cycle_valid && (cs_evt.ro_write || !cs_evt.cfg_access))
        |=> !bus_error_line_q) else $error("bus error without cause");
    cs_prio_a: assert property (cs_evt.cycle_valid && !cs_evt.cfg_access &&
        !cs_evt.ro_write |=> chip_select_q == ($past(m) & (~$past(m) + 4'h1)))
        else $error("chip select not lowest matching line");
    grant_lock_a: assert property (locked_cycle_sig && core_enable_q
        |=> !(arb_out.grant_ext || arb_out.grant_serial_dma || arb_out.grant_block_dma))
        else $error("grant during locked cycle");
    split_gap_a: assert property (ctl_q[3] && locked_cycle_sig && rmw_read_done
        |=> !address_strobe_line_q) else $error("strobe not split");
    cover property (hit && reg_req.wr);
    cover property (cs_evt.cycle_valid && !$onehot0(m));
    cover property (ctl_q[3] && rmw_read_done);
endmodule
bind sys_ctrl_status sys_ctrl_props u_props (.sys_clk, .reset_n, .reg_req, .reg_rsp,
    .wdog_expired, .cs_evt, .chip_select_q, .bus_error_line_q, .locked_cycle_sig,
    .rmw_read_done, .address_strobe_line_q, .arb_out, .core_enable_q);

// >>> dv/core_model.sv
// Core-side model: address strobe and locked read-modify-write cycles.
// Drives its outputs only just after rising edges of sys_clk.
`timescale 1ns/100ps
module core_model (
    input wire logic sys_clk,
    output logic core_as_req,
    output logic locked_cycle_sig,
    output logic rmw_read_done,
    output logic rmw_write_start
);
    initial begin
        {core_as_req, locked_cycle_sig, rmw_read_done, rmw_write_start} = 4'h0;
    end
    // Read part, gap of n cycles, write part; synchronous to sys_clk
    task automatic rmw(input int n);
        @(posedge sys_clk);
        {core_as_req, locked_cycle_sig} <= 2'h3;
        repeat (2) @(posedge sys_clk);
        rmw_read_done <= 1'b1;
        @(posedge sys_clk);
        rmw_read_done <= 1'b0;
        repeat (n) @(posedge sys_clk);
        rmw_write_start <= 1'b1;
        @(posedge sys_clk);
        rmw_write_start <= 1'b0;
        repeat (2) @(posedge sys_clk);
        {core_as_req, locked_cycle_sig} <= 2'h0;
    endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench for sys_ctrl_status.
// Uses core_model for locked cycles; the checker is bound separately.
`timescale 1ns/100ps
module tb;
    import sys_ctrl_pkg::*;
    logic sys_clk, reset_n, core_irq_pending, wdog_expired, bus_error_line_q, core_as_req;
    logic locked_cycle_sig, rmw_read_done, rmw_write_start, address_strobe_line_q;
    logic bus_request_line, bus_grant_line, bus_clear_in, ext_master_cycle, cs_ack_used;
    logic periph_access, extra_wait_q, core_disable_in, core_enable_q, vector_enable_q;
    logic [3:0] chip_select_q;
    logic [2:0] irq_level_line, irq_level_out_q, irq_level_out_oe_q;
    reg_req_t reg_req;
    reg_rsp_t reg_rsp;
    cs_evt_t cs_evt;
    arb_in_t arb_in;
    arb_out_t arb_out;
    logic [2:0] grants;
    assign grants = {arb_out.grant_ext, arb_out.grant_serial_dma, arb_out.grant_block_dma};
    int error_cnt = 0;
    int n_tests = 0;
    sys_ctrl_status DUT (.sys_clk, .reset_n, .reg_req, .reg_rsp, .core_irq_pending,
        .wdog_expired, .cs_evt, .chip_select_q, .bus_error_line_q, .core_as_req,
        .locked_cycle_sig, .rmw_read_done, .rmw_write_start, .address_strobe_line_q, .arb_in,
        .arb_out, .bus_request_line, .bus_grant_line, .bus_clear_in, .ext_master_cycle,
        .cs_ack_used, .periph_access, .extra_wait_q, .core_disable_in, .core_enable_q,
        .irq_level_line, .irq_level_out_q, .irq_level_out_oe_q, .vector_enable_q);
    core_model u_core (.sys_clk, .core_as_req, .locked_cycle_sig, .rmw_read_done,
        .rmw_write_start);
    always #10 sys_clk = ~sys_clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic acc(input logic w, input logic [2:0] fc, input logic [23:0] a,
        input logic [31:0] d, input logic ak, input logic [31:0] e);
        @(posedge sys_clk);
        reg_req <= '{1'b1, w, fc, a, d};
        @(posedge sys_clk);
        reg_req.sel <= 1'b0;
        #1;
        chk("ack", {31'h0, ak}, {31'h0, reg_rsp.ack});
        chk("rdata", e, reg_rsp.rdata);
    endtask
    task automatic wr(input logic [31:0] d);
        acc(1'b1, FC_SUPV_DATA, SCW_ADDR, d, 1'b1, 32'h0);
    endtask
    task automatic rd(input logic [31:0] e);
        acc(1'b0, FC_SUPV_DATA, SCW_ADDR, 32'h0, 1'b1, e);
    endtask
    task automatic ev(input logic wd, input cs_evt_t e, input logic er, input logic [3:0] cs);
        @(posedge sys_clk);
        wdog_expired <= wd;
        cs_evt <= e;
        @(posedge sys_clk);
        {wdog_expired, cs_evt} <= '0;
        #1;
        chk("bus_error", {31'h0, er}, {31'h0, bus_error_line_q});
        chk("chip_select", {28'h0, cs}, {28'h0, chip_select_q});
    endtask
    task automatic pend();
        @(posedge sys_clk);
        core_irq_pending <= 1'b1;
        @(posedge sys_clk);
        core_irq_pending <= 1'b0;
        tick(4);
    endtask
    task automatic split_chk(input logic exp);
        fork
            u_core.rmw(2);
            begin
                tick(6);
                chk("strobe", {31'h0, exp}, {31'h0, address_strobe_line_q});
            end
        join
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {sys_clk, reset_n, core_irq_pending, wdog_expired, bus_request_line} = '0;
        {bus_grant_line, bus_clear_in, ext_master_cycle, cs_ack_used, periph_access} = '0;
        {core_disable_in, reg_req, cs_evt, arb_in} = '0;
        irq_level_line = 3'h5;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        acc(1'b0, 3'h6, SCW_ADDR, 32'h0, 1'b0, 32'h0);
        acc(1'b1, FC_SUPV_DATA, 24'h0000F8, 32'hFFFFFFFF, 1'b0, 32'h0);
        rd(32'h0);
        wr(32'hFFFFFFFF);
        rd(32'h000F8000);
        wr(32'h0);
        chk("core_enable", 32'h1, {31'h0, core_enable_q});
        chk("vector_enable", 32'h1, {31'h0, vector_enable_q});
        $display("test register access done");
        ev(1'b1, '0, 1'b1, 4'h0);
        ev(1'b1, '0, 1'b1, 4'h0);
        ev(1'b0, '{1'b1, 1'b0, 4'h1, 1'b1}, 1'b0, 4'h0);
        ev(1'b0, '{1'b1, 1'b0, 4'h6, 1'b0}, 1'b0, 4'h2);
        rd(32'h70000000);
        wr(32'h30000000);
        rd(32'h40000000);
        wr(32'h00030000);
        ev(1'b0, '{1'b1, 1'b1, 4'h6, 1'b0}, 1'b0, 4'h0);
        rd(32'h40030000);
        ev(1'b0, '{1'b1, 1'b0, 4'h1, 1'b1}, 1'b1, 4'h0);
        ev(1'b0, '{1'b1, 1'b0, 4'hC, 1'b0}, 1'b1, 4'h4);
        ev(1'b0, '{1'b1, 1'b0, 4'hC, 1'b0}, 1'b1, 4'h4);
        rd(32'h70030000);
        fork
            wr(32'hF0030000);
            ev(1'b1, '0, 1'b1, 4'h0);
        join
        rd(32'h40030000);
        wr(32'h40008000);
        $display("test event flags done");
        pend();
        chk("bus_clear", 32'h1, {31'h0, arb_out.bus_clear});
        chk("int_bus_clear", 32'h1, {31'h0, arb_out.internal_bus_clear});
        rd(32'h80008000);
        wr(32'h80008000);
        tick(2);
        chk("bus_clear", 32'h0, {31'h0, arb_out.bus_clear});
        wr(32'h0);
        pend();
        chk("bus_clear", 32'h0, {31'h0, arb_out.bus_clear});
        rd(32'h80000000);
        wr(32'h80000000);
        $display("test bus clear done");
        @(posedge sys_clk);
        arb_in <= '{1'b0, 1'b1, 1'b1};
        tick(2);
        chk("grants", 32'h1, {29'h0, grants});
        chk("core_req", 32'h1, {31'h0, arb_out.core_req});
        @(posedge sys_clk);
        arb_in <= '{1'b1, 1'b1, 1'b1};
        tick(2);
        chk("grants", 32'h2, {29'h0, grants});
        @(posedge sys_clk);
        bus_request_line <= 1'b1;
        tick(4);
        chk("grants", 32'h4, {29'h0, grants});
        fork
            u_core.rmw(3);
            begin
                tick(4);
                chk("grants", 32'h0, {29'h0, grants});
            end
        join
        @(posedge sys_clk);
        {bus_request_line, arb_in} <= '0;
        $display("test arbiter done");
        wr(32'h00040000);
        split_chk(1'b0);
        wr(32'h0);
        split_chk(1'b1);
        wr(32'h00080000);
        @(posedge sys_clk);
        {ext_master_cycle, periph_access} <= 2'h3;
        tick(2);
        chk("extra_wait", 32'h1, {31'h0, extra_wait_q});
        wr(32'h0);
        tick(2);
        chk("extra_wait", 32'h0, {31'h0, extra_wait_q});
        $display("test strobe and wait done");
        ev(1'b1, '0, 1'b1, 4'h0);
        @(posedge sys_clk);
        {reset_n, core_disable_in} <= 2'h1;
        {bus_grant_line, bus_clear_in} <= 2'h3;
        arb_in <= '{1'b1, 1'b0, 1'b0};
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        tick(3);
        chk("core_enable", 32'h0, {31'h0, core_enable_q});
        chk("vector_enable", 32'h0, {31'h0, vector_enable_q});
        chk("irq_oe", 32'h7, {29'h0, irq_level_out_oe_q});
        chk("irq_out", 32'h5, {29'h0, irq_level_out_q});
        chk("dma_request", 32'h1, {31'h0, arb_out.dma_bus_request});
        chk("grants", 32'h2, {29'h0, grants});
        chk("int_bus_clear", 32'h1, {31'h0, arb_out.internal_bus_clear});
        rd(32'h0);
        $display("test core disable done");
        summarize();
    end
endmodule
